/* File: pis_params.svh */
`ifndef PIS_PARAMS_SVH
`define PIS_PARAMS_SVH

// Widths and depths
`define PIS_PC_W          13
`define PIS_STACK_DEPTH   8
`define PIS_SP_W          4
`define PIS_NFLAG         10
`define PIS_ADDR_W        12

// Flag and enable bit positions (same layout in both registers)
`define PIS_FLG_SIF       0
`define PIS_FLG_LVD       1
`define PIS_FLG_UART      2
`define PIS_FLG_EE        3
`define PIS_FLG_PTP       4
`define PIS_FLG_PTA       5
`define PIS_FLG_STP       6
`define PIS_FLG_STA       7
`define PIS_FLG_G0        8
`define PIS_FLG_G1        9
`define PIS_GIE_BIT       10

// Register byte offsets
`define PIS_OFS_ENABLE    12'h000
`define PIS_OFS_FLAGS     12'h004
`define PIS_OFS_SET       12'h008
`define PIS_OFS_STATUS    12'h00C

// Reset values
`define PIS_ENABLE_RST    10'h000
`define PIS_FLAGS_RST     10'h000
`define PIS_GIE_RST       1'b0

// Vector addresses, lowest first wins
`define PIS_VEC_NONE      13'h0000
`define PIS_VEC_SIF       13'h0010
`define PIS_VEC_LVD       13'h0014
`define PIS_VEC_G0        13'h0018
`define PIS_VEC_G1        13'h001C

`endif

/* File: pis_pkg.sv */
`include "pis_params.svh"

package pis_pkg;

    typedef enum logic [2:0] {
        PIS_SRC_NONE,
        PIS_SRC_SIF,
        PIS_SRC_LVD,
        PIS_SRC_GRP0,
        PIS_SRC_GRP1
    } pis_src_t;

    typedef struct packed {
        logic [`PIS_NFLAG-1:0] enable;
        logic                  gie;
        logic [`PIS_NFLAG-1:0] flags;
        logic                  lvd_s1;
        logic                  lvd_s2;
        logic                  lvd_s3;
        pis_src_t              src;
        logic                  irq_req;
        logic [`PIS_PC_W-1:0]  irq_vector;
        logic [`PIS_PC_W-1:0]  return_pc;
        logic                  wake;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
    } pis_state_t;

    typedef struct packed {
        logic [`PIS_STACK_DEPTH-1:0][`PIS_PC_W-1:0] mem;
        logic [`PIS_SP_W-1:0]                       cnt;
    } pis_stack_state_t;

endpackage

/* File: pis_stack.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pis_params.svh"

module pis_stack
    import pis_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire logic                 push,
    input  wire logic                 pop,
    input  wire logic [`PIS_PC_W-1:0] push_pc,
    output logic      [`PIS_PC_W-1:0] top_pc,
    output logic                      full_next,
    output logic      [`PIS_SP_W-1:0] depth
);

    pis_stack_state_t q;
    pis_stack_state_t d;

    // Only the program counter is kept; nothing else is saved on entry
    always_comb begin
        d = q;
        top_pc = '0;
        if (q.cnt != '0) begin
            top_pc = q.mem[q.cnt - `PIS_SP_W'(1)];
        end
        // A push at full depth is dropped; the request gate avoids it for interrupts
        if (push && !pop && q.cnt != `PIS_SP_W'(`PIS_STACK_DEPTH)) begin
            d.mem[q.cnt[2:0]] = push_pc;
            d.cnt = q.cnt + `PIS_SP_W'(1);
        end else if (pop && !push && q.cnt != '0) begin
            d.cnt = q.cnt - `PIS_SP_W'(1);
        end else if (pop && push && q.cnt != '0) begin
            d.mem[q.cnt[2:0] - 3'd1] = push_pc;
        end
        full_next = (d.cnt == `PIS_SP_W'(`PIS_STACK_DEPTH));
        depth = q.cnt;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

/* File: pis_irq_ctrl.sv */
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "pis_params.svh"

module pis_irq_ctrl
    import pis_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   nrst,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`PIS_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   sif_byte_done,
    input  wire logic                   sif_addr_match,
    input  wire logic                   sif_timeout,
    input  wire logic [5:0]             serial_port_event_n,
    input  wire logic                   low_supply_detect,
    input  wire logic                   eeprom_write_done,
    input  wire logic [3:0]             timer_match,
    input  wire logic [`PIS_PC_W-1:0]   core_pc,
    input  wire logic                   core_take,
    input  wire logic                   call_op,
    input  wire logic                   subroutine_return_op,
    input  wire logic                   return_from_interrupt_op,
    input  wire logic                   sleeping,
    output logic                        irq_req,
    output logic      [`PIS_PC_W-1:0]   irq_vector,
    output logic      [`PIS_PC_W-1:0]   return_pc,
    output logic                        wake
);

    pis_state_t q;
    pis_state_t d;

    logic [7:0]            ev;
    logic [`PIS_NFLAG-1:0] sw_clr;
    logic [`PIS_NFLAG-1:0] sw_set;
    logic [`PIS_NFLAG-1:0] svc_clr;
    logic                  wr;
    logic                  acc_setup;
    logic                  svc;
    logic                  sif_any;
    logic                  p_sif;
    logic                  p_lvd;
    logic                  p_g0;
    logic                  p_g1;
    logic                  stk_push;
    logic                  stk_pop;
    logic                  stk_full;
    logic [`PIS_PC_W-1:0]  stk_top;
    logic [`PIS_SP_W-1:0]  stk_depth;

    ////////////////////////////////////////////////////////////////////////
    // Return stack

    assign stk_push = svc | call_op;
    assign stk_pop  = subroutine_return_op | return_from_interrupt_op;

    pis_stack u_stack (
        .clock     (clock),
        .nrst      (nrst),
        .push      (stk_push),
        .pop       (stk_pop),
        .push_pc   (core_pc),
        .top_pc    (stk_top),
        .full_next (stk_full),
        .depth     (stk_depth)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d = q;
        sif_any = sif_byte_done | sif_addr_match | sif_timeout;
        ev = '0;
        ev[`PIS_FLG_SIF] = sif_any;
        ev[`PIS_FLG_LVD] = q.lvd_s2 & ~q.lvd_s3;
        // Any low bit is a live condition; the port pulses low, not a level
        ev[`PIS_FLG_UART] = ~&serial_port_event_n;
        ev[`PIS_FLG_EE] = eeprom_write_done;
        ev[`PIS_FLG_STA:`PIS_FLG_PTP] = timer_match;

        // Supply detector is asynchronous to this clock
        d.lvd_s1 = low_supply_detect;
        d.lvd_s2 = q.lvd_s1;
        d.lvd_s3 = q.lvd_s2;

        acc_setup = psel & ~penable;
        wr = psel & penable & q.pready & pwrite;
        sw_clr = '0;
        sw_set = '0;
        if (wr && paddr == `PIS_OFS_FLAGS) begin
            sw_clr = pwdata[`PIS_NFLAG-1:0];
        end
        if (wr && paddr == `PIS_OFS_SET) begin
            sw_set = pwdata[`PIS_NFLAG-1:0];
        end

        svc = core_take & q.irq_req;
        svc_clr = '0;
        if (svc) begin
            case (q.src)
                PIS_SRC_SIF:  svc_clr[`PIS_FLG_SIF] = 1'b1;
                PIS_SRC_LVD:  svc_clr[`PIS_FLG_LVD] = 1'b1;
                // Member flags stay set; software must clear them
                PIS_SRC_GRP0: svc_clr[`PIS_FLG_G0] = 1'b1;
                PIS_SRC_GRP1: svc_clr[`PIS_FLG_G1] = 1'b1;
                default: ;
            endcase
        end

        // New events beat any clear in the same cycle
        d.flags[7:0] = ev | sw_set[7:0] | (q.flags[7:0] & ~sw_clr[7:0] & ~svc_clr[7:0]);
        d.flags[`PIS_FLG_G0] = (|(d.flags[`PIS_FLG_EE:`PIS_FLG_UART] & ~q.flags[`PIS_FLG_EE:`PIS_FLG_UART]))
                             | sw_set[`PIS_FLG_G0]
                             | (q.flags[`PIS_FLG_G0] & ~sw_clr[`PIS_FLG_G0] & ~svc_clr[`PIS_FLG_G0]);
        d.flags[`PIS_FLG_G1] = (|(d.flags[`PIS_FLG_STA:`PIS_FLG_PTP] & ~q.flags[`PIS_FLG_STA:`PIS_FLG_PTP]))
                             | sw_set[`PIS_FLG_G1]
                             | (q.flags[`PIS_FLG_G1] & ~sw_clr[`PIS_FLG_G1] & ~svc_clr[`PIS_FLG_G1]);

        if (wr && paddr == `PIS_OFS_ENABLE) begin
            d.enable = pwdata[`PIS_NFLAG-1:0];
            d.gie = pwdata[`PIS_GIE_BIT];
        end
        if (return_from_interrupt_op) begin
            d.gie = 1'b1;
        end
        // A plain return has no effect on the global enable
        if (svc) begin
            d.gie = 1'b0;
        end

        if (stk_pop) begin
            d.return_pc = stk_top;
        end

        // Judged on next state so a taken request drops at once
        p_sif = d.gie & ~stk_full & d.enable[`PIS_FLG_SIF] & d.flags[`PIS_FLG_SIF];
        p_lvd = d.gie & ~stk_full & d.enable[`PIS_FLG_LVD] & d.flags[`PIS_FLG_LVD];
        p_g0 = d.gie & ~stk_full & d.enable[`PIS_FLG_G0] & d.flags[`PIS_FLG_G0]
             & (|(d.enable[`PIS_FLG_EE:`PIS_FLG_UART] & d.flags[`PIS_FLG_EE:`PIS_FLG_UART]));
        p_g1 = d.gie & ~stk_full & d.enable[`PIS_FLG_G1] & d.flags[`PIS_FLG_G1]
             & (|(d.enable[`PIS_FLG_STA:`PIS_FLG_PTP] & d.flags[`PIS_FLG_STA:`PIS_FLG_PTP]));

        d.irq_req = p_sif | p_lvd | p_g0 | p_g1;
        if (p_sif) begin
            d.src = PIS_SRC_SIF;
            d.irq_vector = `PIS_VEC_SIF;
        end else if (p_lvd) begin
            d.src = PIS_SRC_LVD;
            d.irq_vector = `PIS_VEC_LVD;
        end else if (p_g0) begin
            d.src = PIS_SRC_GRP0;
            d.irq_vector = `PIS_VEC_G0;
        end else if (p_g1) begin
            d.src = PIS_SRC_GRP1;
            d.irq_vector = `PIS_VEC_G1;
        end else begin
            d.src = PIS_SRC_NONE;
            d.irq_vector = `PIS_VEC_NONE;
        end

        // Enables play no part in waking
        d.wake = sleeping & (|(d.flags & ~q.flags));

        // Zero-wait slave: ready is raised for the access cycle
        d.pready = acc_setup;
        d.pslverr = 1'b0;
        d.prdata = '0;
        if (acc_setup) begin
            case (paddr)
                `PIS_OFS_ENABLE: d.prdata = pwrite ? '0 : 32'({q.gie, q.enable});
                `PIS_OFS_FLAGS:  d.prdata = pwrite ? '0 : 32'(q.flags);
                `PIS_OFS_SET:    d.prdata = '0;
                `PIS_OFS_STATUS: d.prdata = pwrite ? '0 : 32'({q.irq_vector, stk_depth, q.src, q.irq_req});
                default:         d.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.enable <= `PIS_ENABLE_RST;
            q.flags <= `PIS_FLAGS_RST;
            q.gie <= `PIS_GIE_RST;
        end else begin
            q <= d;
        end
    end

    assign prdata     = q.prdata;
    assign pready     = q.pready;
    assign pslverr    = q.pslverr;
    assign irq_req    = q.irq_req;
    assign irq_vector = q.irq_vector;
    assign return_pc  = q.return_pc;
    assign wake       = q.wake;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    property p_sif_set;
        sif_timeout |=> q.flags[`PIS_FLG_SIF];
    endproperty
    a_sif_set: assert property (p_sif_set) else $error("serial module flag not set");

    property p_sif_gate;
        q.irq_req && q.src == PIS_SRC_SIF |-> q.gie && q.enable[`PIS_FLG_SIF] && q.flags[`PIS_FLG_SIF];
    endproperty
    a_sif_gate: assert property (p_sif_gate) else $error("serial module vector without enables");

    property p_sif_svc;
        core_take && q.irq_req && q.src == PIS_SRC_SIF && !sif_any && !return_from_interrupt_op
        |=> !q.flags[`PIS_FLG_SIF] && !q.gie && !q.irq_req;
    endproperty
    a_sif_svc: assert property (p_sif_svc) else $error("serial module service did not clear");

    property p_uart_pulse;
        $fell(serial_port_event_n[0]) |=> q.flags[`PIS_FLG_UART]
            && (q.flags[`PIS_FLG_G0] || !$rose(q.flags[`PIS_FLG_UART]));
    endproperty
    a_uart_pulse: assert property (p_uart_pulse) else $error("serial port pulse lost");

    property p_grp_keep;
        core_take && q.irq_req && q.src == PIS_SRC_GRP0 && q.flags[`PIS_FLG_UART] && !wr
        |=> q.flags[`PIS_FLG_UART] && !q.gie;
    endproperty
    a_grp_keep: assert property (p_grp_keep) else $error("member flag cleared by service");

    property p_lvd_set;
        $rose(q.lvd_s2) |=> q.flags[`PIS_FLG_LVD];
    endproperty
    a_lvd_set: assert property (p_lvd_set) else $error("low supply flag not set");

    property p_tmr_gate;
        q.irq_req && q.src == PIS_SRC_GRP1 |-> q.gie && q.enable[`PIS_FLG_G1] && q.flags[`PIS_FLG_G1]
            && |(q.enable[`PIS_FLG_STA:`PIS_FLG_PTP] & q.flags[`PIS_FLG_STA:`PIS_FLG_PTP]);
    endproperty
    a_tmr_gate: assert property (p_tmr_gate) else $error("timer vector without enables");

    property p_wake;
        sleeping && eeprom_write_done && !q.flags[`PIS_FLG_EE] |=> wake;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on flag rise");

    property p_hold;
        q.flags[`PIS_FLG_EE] && !(wr && paddr == `PIS_OFS_FLAGS) |=> q.flags[`PIS_FLG_EE];
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped without clear");

    property p_return_from_interrupt_op;
        return_from_interrupt_op && !svc |=> q.gie;
    endproperty
    a_return_from_interrupt_op: assert property (p_return_from_interrupt_op) else $error("global enable not restored");

    property p_ret;
        subroutine_return_op && !q.gie && !return_from_interrupt_op && !wr |=> !q.gie;
    endproperty
    a_ret: assert property (p_ret) else $error("plain return changed global enable");

    property p_prio;
        q.irq_req && q.src != PIS_SRC_SIF |-> !(q.enable[`PIS_FLG_SIF] && q.flags[`PIS_FLG_SIF]);
    endproperty
    a_prio: assert property (p_prio) else $error("priority order broken");

    property p_uart_set;
        !(&serial_port_event_n) |=> q.flags[`PIS_FLG_UART];
    endproperty
    a_uart_set: assert property (p_uart_set) else $error("serial port flag not set");

    property p_lvd_svc;
        core_take && q.irq_req && q.src == PIS_SRC_LVD && !(q.lvd_s2 && !q.lvd_s3) && !wr
        |=> !q.flags[`PIS_FLG_LVD] && !q.gie;
    endproperty
    a_lvd_svc: assert property (p_lvd_svc) else $error("low supply service did not clear");

    property p_ee_set;
        eeprom_write_done |=> q.flags[`PIS_FLG_EE];
    endproperty
    a_ee_set: assert property (p_ee_set) else $error("eeprom flag not set");

    // Service of a group must leave the member flag for software
    property p_ee_keep;
        core_take && q.irq_req && q.src == PIS_SRC_GRP0 && q.flags[`PIS_FLG_EE] && !wr
            && !eeprom_write_done && &serial_port_event_n
        |=> q.flags[`PIS_FLG_EE] && !q.flags[`PIS_FLG_G0] && !q.gie;
    endproperty
    a_ee_keep: assert property (p_ee_keep) else $error("eeprom flag cleared by service");

    property p_tmr_set;
        timer_match != 4'h0
        |=> (q.flags[`PIS_FLG_STA:`PIS_FLG_PTP] & $past(timer_match)) == $past(timer_match);
    endproperty
    a_tmr_set: assert property (p_tmr_set) else $error("timer flag not set");

    property p_tmr_keep;
        core_take && q.irq_req && q.src == PIS_SRC_GRP1 && q.flags[`PIS_FLG_PTP] && !wr && timer_match == 4'h0
        |=> q.flags[`PIS_FLG_PTP] && !q.flags[`PIS_FLG_G1] && !q.gie;
    endproperty
    a_tmr_keep: assert property (p_tmr_keep) else $error("timer flag cleared by service");

    property p_sleep_wake;
        !sleeping |=> !wake;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("wake while not sleeping");

    property p_grp0_set;
        $rose(q.flags[`PIS_FLG_EE]) |-> q.flags[`PIS_FLG_G0];
    endproperty
    a_grp0_set: assert property (p_grp0_set) else $error("group 0 flag not set");

    property p_grp1_set;
        $rose(q.flags[`PIS_FLG_PTA]) |-> q.flags[`PIS_FLG_G1];
    endproperty
    a_grp1_set: assert property (p_grp1_set) else $error("group 1 flag not set");

    // A pending request must never face a full stack
    property p_stk_room;
        q.irq_req |-> stk_depth != `PIS_SP_W'(`PIS_STACK_DEPTH);
    endproperty
    a_stk_room: assert property (p_stk_room) else $error("request with full stack");

    property p_push;
        core_take && q.irq_req && !call_op && !stk_pop |=> stk_depth == $past(stk_depth) + `PIS_SP_W'(1);
    endproperty
    a_push: assert property (p_push) else $error("entry did not push one word");

endmodule

`default_nettype wire

/* File: pis_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pis_params.svh"

// Stand-in for the core sequencer: takes a presented request promptly or after a stall
module pis_core_model
    import pis_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire logic                 accept,
    input  wire logic                 slow,
    input  wire logic                 irq_req,
    output logic                      core_take,
    output logic      [`PIS_PC_W-1:0] core_pc
);
    logic [1:0] wait_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            core_take <= 1'b0;
            core_pc   <= 13'h0100;
            wait_q    <= 2'h0;
        end else begin
            // PC moves every cycle so each push carries a distinct value
            core_pc   <= core_pc + 13'h0001;
            // One-cycle take, only while a request stands, so one request is taken once
            core_take <= accept && irq_req && !core_take && (!slow || wait_q == 2'h3);
            wait_q    <= (irq_req && !core_take) ? wait_q + 2'h1 : 2'h0;
        end
    end
endmodule

`default_nettype wire

/* File: peripheral_interrupt_sources_wakeup_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pis_params.svh"

module peripheral_interrupt_sources_wakeup_bench
    import pis_pkg::*;
;
    logic        clock, nrst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        rerr, sif_byte_done, sif_addr_match, sif_timeout;
    logic [5:0]  serial_port_event_n;
    logic        low_supply_detect, eeprom_write_done, core_take, call_op;
    logic [3:0]  timer_match;
    logic [12:0] core_pc, irq_vector, return_pc;
    logic        subroutine_return_op, return_from_interrupt_op, sleeping;
    logic        irq_req, wake, accept, slow;
    logic [12:0] vec_q[$];
    logic [12:0] pc_q[$];
    logic [12:0] vec_exp[4] = '{`PIS_VEC_SIF, `PIS_VEC_LVD, `PIS_VEC_G0, `PIS_VEC_G1};
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          wake_cnt = 0;
    int          cycles = 0;

    pis_irq_ctrl dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sif_byte_done(sif_byte_done), .sif_addr_match(sif_addr_match), .sif_timeout(sif_timeout),
        .serial_port_event_n(serial_port_event_n), .low_supply_detect(low_supply_detect),
        .eeprom_write_done(eeprom_write_done), .timer_match(timer_match), .core_pc(core_pc),
        .core_take(core_take), .call_op(call_op), .subroutine_return_op(subroutine_return_op),
        .return_from_interrupt_op(return_from_interrupt_op), .sleeping(sleeping),
        .irq_req(irq_req), .irq_vector(irq_vector), .return_pc(return_pc), .wake(wake));

    pis_core_model core (.clock(clock), .nrst(nrst), .accept(accept), .slow(slow),
        .irq_req(irq_req), .core_take(core_take), .core_pc(core_pc));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Entered and left just after a rising edge; the request holds until pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        chk(32'(n), 32'h0000_0001);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, exp);
    endtask

    // Bit i of m raises source i; k picks which serial condition does it
    task automatic fire(input logic [7:0] m, input int k);
        sif_byte_done       <= m[0] && k % 3 == 0;
        sif_addr_match      <= m[0] && k % 3 == 1;
        sif_timeout         <= m[0] && k % 3 == 2;
        serial_port_event_n <= ~(6'(m[2]) << k);
        eeprom_write_done   <= m[3];
        timer_match         <= m[7:4];
        low_supply_detect   <= m[1];
        @(posedge clock);
        {sif_byte_done, sif_addr_match, sif_timeout, eeprom_write_done} <= 4'h0;
        serial_port_event_n <= 6'h3f;
        timer_match         <= 4'h0;
        // Detector level must outlast its synchroniser
        repeat (4) @(posedge clock);
        low_supply_detect <= 1'b0;
        @(posedge clock);
    endtask

    function automatic logic [31:0] exp_flags(input logic [7:0] m);
        return {22'h00_0000, |m[7:4], |m[3:2], m};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        cycles++;
        if (core_take === 1'b1 && irq_req === 1'b1) begin
            vec_q.push_back(irq_vector);
            pc_q.push_back(core_pc);
        end
        if (wake === 1'b1) begin
            wake_cnt++;
        end
        if (cycles == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        logic [7:0] m;
        int         k;
        {nrst, psel, penable, pwrite, sif_byte_done, sif_addr_match, sif_timeout} = 7'h00;
        {low_supply_detect, eeprom_write_done, call_op, sleeping, accept, slow} = 6'h00;
        {subroutine_return_op, return_from_interrupt_op} = 2'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        serial_port_event_n = 6'h3f;
        timer_match = 4'h0;
        k = $urandom(18147);
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        for (k = 0; k < 16; k += 4) begin
            rdchk(12'(k), 32'h0000_0000);
        end
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(32'(rerr), 32'h0000_0001);
        // Random sources with random enables but the global enable kept low
        for (int i = 0; i < 8; i++) begin
            // First two passes hit serial bit 0 and the serial time-out on purpose
            m = (i < 2) ? 8'hff : 8'($urandom);
            k = (i == 0) ? 0 : (i == 1) ? 5 : $urandom_range(5);
            apb(1'b1, `PIS_OFS_ENABLE, {22'h00_0000, 10'($urandom)});
            fire(m, k);
            rdchk(`PIS_OFS_FLAGS, exp_flags(m));
            chk(32'(irq_req), 32'h0000_0000);
            apb(1'b1, `PIS_OFS_FLAGS, 32'h0000_03ff);
        end
        // All sources pending, served one by one in vector order
        apb(1'b1, `PIS_OFS_ENABLE, 32'h0000_03ff);
        fire(8'hff, 1);
        accept <= 1'b1;
        slow   <= 1'b1;
        apb(1'b1, `PIS_OFS_ENABLE, 32'h0000_07ff);
        for (int i = 0; i < 4; i++) begin
            k = 0;
            while (vec_q.size() <= i && k < 50) begin
                @(posedge clock);
                k++;
            end
            chk(32'(vec_q[i]), 32'(vec_exp[i]));
            rdchk(`PIS_OFS_ENABLE, 32'h0000_03ff);
            slow <= ~slow;
            if (i == 0) begin
                subroutine_return_op <= 1'b1;
            end else begin
                return_from_interrupt_op <= 1'b1;
            end
            @(posedge clock);
            {subroutine_return_op, return_from_interrupt_op} <= 2'h0;
            @(posedge clock);
            chk(32'(return_pc), 32'(pc_q[i]));
            if (i == 0) begin
                rdchk(`PIS_OFS_ENABLE, 32'h0000_03ff);
                apb(1'b1, `PIS_OFS_ENABLE, 32'h0000_07ff);
            end
        end
        rdchk(`PIS_OFS_ENABLE, 32'h0000_07ff);
        rdchk(`PIS_OFS_FLAGS, 32'h0000_00fc);
        // Wake-up with every enable off; a preset flag cannot rise
        accept <= 1'b0;
        apb(1'b1, `PIS_OFS_ENABLE, 32'h0000_0000);
        apb(1'b1, `PIS_OFS_FLAGS, 32'h0000_03ff);
        apb(1'b1, `PIS_OFS_SET, 32'h0000_0388);
        sleeping <= 1'b1;
        wake_cnt = 0;
        fire(8'h80, 0);
        chk(32'(wake_cnt), 32'h0000_0000);
        fire(8'h20, 0);
        chk(32'(wake_cnt), 32'h0000_0001);
        // Ordinary call and return share the stack with interrupt entry
        call_op <= 1'b1;
        @(posedge clock);
        pc_q.push_back(core_pc);
        call_op <= 1'b0;
        subroutine_return_op <= 1'b1;
        @(posedge clock);
        subroutine_return_op <= 1'b0;
        @(posedge clock);
        chk(32'(return_pc), 32'(pc_q[4]));
        complete_run();
    end
endmodule

`default_nettype wire
